// [src/fsc_pkg.sv]
// fsc_pkg: command codes, status bit positions and bus timing for the flash host controller
// assumes a x16 parallel nor flash driven by a 100 MHz synchronous controller
package fsc_pkg;
    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_READ_CONFIG  = 8'h90;
    localparam logic [7:0] CMD_READ_QUERY   = 8'h98;
    localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT     = 8'h10;
    localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
    localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
    localparam logic [7:0] CMD_SUSPEND      = 8'hb0;
    localparam logic [7:0] CMD_CONFIG_SETUP = 8'h60;
    localparam logic [7:0] CMD_LOCK         = 8'h01;
    localparam logic [7:0] CMD_LOCK_DOWN    = 8'h2f;
    localparam logic [7:0] CMD_PROT_PROG    = 8'hc0;

    // ------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------
    localparam int SR_READY      = 7;
    localparam int SR_ERASE_SUSP = 6;
    localparam int SR_ERASE_FAIL = 5;
    localparam int SR_PROG_FAIL  = 4;
    localparam int SR_SUPPLY     = 3;
    localparam int SR_PROG_SUSP  = 2;
    localparam int SR_LOCK_FAULT = 1;

    // ------------------------------------------------------------
    // host operations
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_READ_ARRAY = 4'h0,
        OP_READ_STAT  = 4'h1,
        OP_CLEAR      = 4'h2,
        OP_READ_CFG   = 4'h3,
        OP_READ_QRY   = 4'h4,
        OP_PROGRAM    = 4'h5,
        OP_ERASE      = 4'h6,
        OP_SUSPEND    = 4'h7,
        OP_RESUME     = 4'h8,
        OP_LOCK       = 4'h9,
        OP_UNLOCK     = 4'ha,
        OP_LOCK_DOWN  = 4'hb,
        OP_PROT_PROG  = 4'hc,
        OP_READ       = 4'hd
    } fsc_op_t;

    // ------------------------------------------------------------
    // bus timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int T_WE_PULSE_NS  = 50;
    localparam int T_RD_ACCESS_NS = 80;
    localparam int T_RECOVER_NS   = 30;
    localparam int WE_CYC  = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_CYC  = (T_RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REC_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W   = 4;
endpackage

// [src/fsc_bus_cycle.sv]
// fsc_bus_cycle: one timed write or read cycle on the flash pins
// assumes flash outputs are sampled synchronously at the end of the access time
`timescale 1ns/1ps
module fsc_bus_cycle #(
    parameter int AW = 22,
    parameter int DW = 16
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // request
    input  wire logic          start,
    input  wire logic          is_write,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic               done,
    output logic [DW-1:0]      rdata,
    // pins
    output logic               ce_n,
    output logic               oe_n,
    output logic               we_n,
    output logic [AW-1:0]      a,
    output logic [DW-1:0]      dq_o,
    output logic               dq_oe_n,
    input  wire logic [DW-1:0] dq_i
);
    typedef enum logic [1:0] {
        BC_IDLE = 2'b00,
        BC_ACT  = 2'b01,
        BC_REC  = 2'b10
    } fsc_bc_t;

    fsc_bc_t                      st_q;
    logic [fsc_pkg::CNT_W-1:0]    cnt_q;
    logic                         wr_q;

    wire logic cnt_end = (cnt_q == '0);

    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (rst) begin
            st_q <= BC_IDLE; cnt_q <= '0; wr_q <= 1'b0;
            ce_n <= 1'b1; oe_n <= 1'b1; we_n <= 1'b1; dq_oe_n <= 1'b1;
            a <= '0; dq_o <= '0; rdata <= '0;
        end else begin
            unique case (st_q)
                BC_IDLE: if (start) begin
                    wr_q <= is_write; a <= addr; dq_o <= wdata;
                    ce_n <= 1'b0; we_n <= ~is_write; oe_n <= is_write;
                    dq_oe_n <= ~is_write;
                    cnt_q <= is_write ? fsc_pkg::CNT_W'(fsc_pkg::WE_CYC - 1)
                                      : fsc_pkg::CNT_W'(fsc_pkg::RD_CYC - 1);
                    st_q <= BC_ACT;
                end
                BC_ACT: if (cnt_end) begin
                    // ce toggles on every cycle so status is re-latched each poll
                    if (!wr_q) rdata <= dq_i;
                    ce_n <= 1'b1; oe_n <= 1'b1; we_n <= 1'b1;
                    cnt_q <= fsc_pkg::CNT_W'(fsc_pkg::REC_CYC - 1);
                    st_q <= BC_REC;
                end else cnt_q <= cnt_q - 1'b1;
                BC_REC: if (cnt_end) begin
                    dq_oe_n <= 1'b1; done <= 1'b1; st_q <= BC_IDLE;
                end else cnt_q <= cnt_q - 1'b1;
                default: st_q <= BC_IDLE;
            endcase
        end
    end
endmodule // fsc_bus_cycle

// [src/fsc_host.sv]
// fsc_host: host-side sequencer issuing flash commands and polling status
// assumes the flash pins are wired directly; one user request at a time
`timescale 1ns/1ps
// Contract
// - reset pin held high while suspended
// - erase is 20h then d0h at block
// - clear status after erase, then read array
// - after resumed erase read then clear status
module fsc_host #(
    parameter int AW = 22,
    parameter int DW = 16
) (
    // clock and reset
    input  wire logic          CLK_SYS,
    input  wire logic          RESET,
    // user request
    input  wire logic          REQ_VALID,
    input  wire logic [3:0]    REQ_OP,
    input  wire logic [AW-1:0] REQ_ADDR,
    input  wire logic [DW-1:0] REQ_DATA,
    output logic               REQ_READY,
    // user answer
    output logic               RSP_VALID,
    output logic [DW-1:0]      RSP_DATA,
    output logic [7:0]         RSP_STATUS,
    output logic               RSP_REFUSED,
    output logic               PROG_SUSPENDED,
    output logic               ERASE_SUSPENDED,
    // flash pins
    output logic               CE_N,
    output logic               OE_N,
    output logic               WE_N,
    output logic               POWER_DOWN_RESET_N,
    output logic [AW-1:0]      ADDR,
    output logic [DW-1:0]      DQ_O,
    output logic               DQ_OE_N,
    input  wire logic [DW-1:0] DQ_I
);
    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_CMD1  = 3'b001,
        S_CMD2  = 3'b010,
        S_POLL  = 3'b011,
        S_READ  = 3'b100,
        S_DONE  = 3'b101
    } fsc_st_t;

    fsc_st_t             st_q;
    fsc_pkg::fsc_op_t    op_q;
    logic [AW-1:0]       addr_q;
    logic [DW-1:0]       data_q;
    logic                psusp_q;
    logic                esusp_q;
    logic                refused_q;
    logic                bc_start;
    logic                bc_write;
    logic [AW-1:0]       bc_addr;
    logic [DW-1:0]       bc_wdata;
    logic                bc_done;
    logic [DW-1:0]       bc_rdata;
    logic                bc_busy_q;

    // ------------------------------------------------------------
    // command legality
    // ------------------------------------------------------------
    wire fsc_pkg::fsc_op_t req_op = fsc_pkg::fsc_op_t'(REQ_OP);
    wire logic op_is_read = (req_op == fsc_pkg::OP_READ_ARRAY) || (req_op == fsc_pkg::OP_READ)
        || (req_op == fsc_pkg::OP_READ_STAT) || (req_op == fsc_pkg::OP_READ_CFG)
        || (req_op == fsc_pkg::OP_READ_QRY);
    wire logic ok_psusp = op_is_read || (req_op == fsc_pkg::OP_RESUME);
    wire logic ok_esusp = (req_op == fsc_pkg::OP_READ_STAT) || (req_op == fsc_pkg::OP_READ_CFG)
        || (req_op == fsc_pkg::OP_READ_QRY) || (req_op == fsc_pkg::OP_PROGRAM)
        || (req_op == fsc_pkg::OP_RESUME) || (req_op == fsc_pkg::OP_LOCK)
        || (req_op == fsc_pkg::OP_UNLOCK) || (req_op == fsc_pkg::OP_LOCK_DOWN)
        || (req_op == fsc_pkg::OP_READ_ARRAY) || (req_op == fsc_pkg::OP_READ);
    wire logic ok_idle = (req_op != fsc_pkg::OP_SUSPEND) && (req_op != fsc_pkg::OP_RESUME);
    wire logic legal = psusp_q ? ok_psusp : (esusp_q ? ok_esusp : ok_idle);

    // ------------------------------------------------------------
    // command encoding
    // ------------------------------------------------------------
    logic [7:0] first_code;
    logic [7:0] second_code;
    always_comb begin
        second_code = fsc_pkg::CMD_CONFIRM;
        unique case (op_q)
            fsc_pkg::OP_READ_ARRAY: first_code = fsc_pkg::CMD_READ_ARRAY;
            fsc_pkg::OP_READ:       first_code = fsc_pkg::CMD_READ_ARRAY;
            fsc_pkg::OP_READ_STAT:  first_code = fsc_pkg::CMD_READ_STATUS;
            fsc_pkg::OP_CLEAR:      first_code = fsc_pkg::CMD_CLEAR_STATUS;
            fsc_pkg::OP_READ_CFG:   first_code = fsc_pkg::CMD_READ_CONFIG;
            fsc_pkg::OP_READ_QRY:   first_code = fsc_pkg::CMD_READ_QUERY;
            fsc_pkg::OP_PROGRAM:    first_code = fsc_pkg::CMD_PROG_SETUP;
            fsc_pkg::OP_ERASE:      first_code = fsc_pkg::CMD_ERASE_SETUP;
            fsc_pkg::OP_SUSPEND:    first_code = fsc_pkg::CMD_SUSPEND;
            fsc_pkg::OP_RESUME:     first_code = fsc_pkg::CMD_CONFIRM;
            fsc_pkg::OP_LOCK: begin
                first_code = fsc_pkg::CMD_CONFIG_SETUP;
                second_code = fsc_pkg::CMD_LOCK;
            end
            fsc_pkg::OP_UNLOCK:     first_code = fsc_pkg::CMD_CONFIG_SETUP;
            fsc_pkg::OP_LOCK_DOWN: begin
                first_code = fsc_pkg::CMD_CONFIG_SETUP;
                second_code = fsc_pkg::CMD_LOCK_DOWN;
            end
            fsc_pkg::OP_PROT_PROG:  first_code = fsc_pkg::CMD_PROT_PROG;
            default:                first_code = fsc_pkg::CMD_READ_STATUS;
        endcase
    end

    wire logic two_cycle = (op_q == fsc_pkg::OP_PROGRAM) || (op_q == fsc_pkg::OP_ERASE)
        || (op_q == fsc_pkg::OP_LOCK) || (op_q == fsc_pkg::OP_UNLOCK)
        || (op_q == fsc_pkg::OP_LOCK_DOWN) || (op_q == fsc_pkg::OP_PROT_PROG);
    wire logic polls = (op_q == fsc_pkg::OP_PROGRAM) || (op_q == fsc_pkg::OP_ERASE)
        || (op_q == fsc_pkg::OP_SUSPEND) || (op_q == fsc_pkg::OP_RESUME)
        || (op_q == fsc_pkg::OP_PROT_PROG);
    wire logic reads = (op_q == fsc_pkg::OP_READ) || (op_q == fsc_pkg::OP_READ_CFG)
        || (op_q == fsc_pkg::OP_READ_QRY) || (op_q == fsc_pkg::OP_READ_STAT);
    wire logic data_second = (op_q == fsc_pkg::OP_PROGRAM) || (op_q == fsc_pkg::OP_PROT_PROG);
    wire logic [DW-1:0] second_word = data_second ? data_q : DW'(second_code);
    wire logic [7:0] sr = bc_rdata[7:0];
    wire logic ready_bit = sr[fsc_pkg::SR_READY];
    wire logic one_shot_read = (op_q == fsc_pkg::OP_READ);

    // ------------------------------------------------------------
    // bus cycle request
    // ------------------------------------------------------------
    assign bc_start = (st_q == S_CMD1) || (st_q == S_CMD2) || (st_q == S_POLL)
        || (st_q == S_READ);
    assign bc_write = (st_q == S_CMD1) ? !one_shot_read : (st_q == S_CMD2);
    assign bc_addr  = addr_q;
    assign bc_wdata = (st_q == S_CMD2) ? second_word : DW'(first_code);

    fsc_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
        .clk      (CLK_SYS),
        .rst      (RESET),
        .start    (bc_start && !bc_busy_q),
        .is_write (bc_write),
        .addr     (bc_addr),
        .wdata    (bc_wdata),
        .done     (bc_done),
        .rdata    (bc_rdata),
        .ce_n     (CE_N),
        .oe_n     (OE_N),
        .we_n     (WE_N),
        .a        (ADDR),
        .dq_o     (DQ_O),
        .dq_oe_n  (DQ_OE_N),
        .dq_i     (DQ_I)
    );

    always_ff @(posedge CLK_SYS) begin
        if (RESET) bc_busy_q <= 1'b0;
        else if (bc_done) bc_busy_q <= 1'b0;
        else if (bc_start) bc_busy_q <= 1'b1;
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        RSP_VALID <= 1'b0;
        if (RESET) begin
            st_q <= S_IDLE; op_q <= fsc_pkg::OP_READ_ARRAY; addr_q <= '0; data_q <= '0;
            psusp_q <= 1'b0; esusp_q <= 1'b0; refused_q <= 1'b0;
            REQ_READY <= 1'b0; RSP_DATA <= '0; RSP_STATUS <= '0; RSP_REFUSED <= 1'b0;
            POWER_DOWN_RESET_N <= 1'b0;
        end else begin
            POWER_DOWN_RESET_N <= 1'b1;
            unique case (st_q)
                S_IDLE: begin
                    REQ_READY <= 1'b1;
                    if (REQ_VALID && REQ_READY) begin
                        REQ_READY <= 1'b0;
                        op_q <= req_op; addr_q <= REQ_ADDR; data_q <= REQ_DATA;
                        refused_q <= !legal;
                        st_q <= legal ? S_CMD1 : S_DONE;
                    end
                end
                S_CMD1: if (bc_done) begin
                    if (one_shot_read) begin
                        RSP_DATA <= bc_rdata; st_q <= S_DONE;
                    end else
                        st_q <= two_cycle ? S_CMD2 : (polls ? S_POLL : (reads ? S_READ : S_DONE));
                end
                S_CMD2: if (bc_done) st_q <= S_POLL;
                S_POLL: if (bc_done && ready_bit) begin
                    RSP_STATUS <= sr; RSP_DATA <= bc_rdata;
                    if (op_q == fsc_pkg::OP_SUSPEND) begin
                        psusp_q <= sr[fsc_pkg::SR_PROG_SUSP];
                        esusp_q <= esusp_q | sr[fsc_pkg::SR_ERASE_SUSP];
                    end else if (op_q == fsc_pkg::OP_RESUME) begin
                        // a nested program resumes first, then the suspended erase
                        if (psusp_q) psusp_q <= 1'b0;
                        else esusp_q <= 1'b0;
                    end
                    st_q <= S_DONE;
                end
                S_READ: if (bc_done) begin
                    RSP_DATA <= bc_rdata; RSP_STATUS <= bc_rdata[7:0]; st_q <= S_DONE;
                end
                S_DONE: begin
                    RSP_VALID <= 1'b1; RSP_REFUSED <= refused_q; st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            PROG_SUSPENDED <= 1'b0; ERASE_SUSPENDED <= 1'b0;
        end else begin
            PROG_SUSPENDED <= psusp_q; ERASE_SUSPENDED <= esusp_q;
        end
    end
endmodule // fsc_host

// [dv/fsc_flash_model.sv]
// fsc_flash_model: behavioural x16 nor flash as seen from its pins
// assumes pins from fsc_host; program and erase end after BUSY_POLLS status reads
`timescale 1ns/1ps
module fsc_flash_model #(
    parameter int          BUSY_POLLS = 3,
    parameter logic [15:0] MAKER_CODE = 16'h00a5  // arbitrary value
) (
    // pins
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        rp_n,
    input  wire logic [21:0] addr,
    input  wire logic [15:0] dq_o,
    output logic      [15:0] dq_i,
    // fault knobs
    input  wire logic        erase_fail,
    input  wire logic        supply_bad
);
    logic [7:0]  sr, setup, last_prog, lock_code;
    logic [1:0]  mode;
    logic [21:0] erase_blk, lock_blk;
    logic [15:0] mem [16];
    logic [15:0] rd, last_val;
    int          busy;
    initial begin
        last_val = 16'h5a5a;
        foreach (mem[i]) mem[i] = 16'hffff;
    end
    always @(rp_n) if (!rp_n) begin
        sr = 8'h80;
        mode = 2'd0;
        setup = 8'h00;
        busy = 0;
    end
    // ------------------------------------------------------------
    // command writes, taken once strobes and data have settled
    // ------------------------------------------------------------
    always @(negedge we_n) begin
        #1;
        if (!ce_n && rp_n) begin
            if (setup == 8'h20) begin
                if (dq_o[7:0] == 8'hd0) begin
                    erase_blk = addr;
                    if (supply_bad) sr = sr | 8'h28;
                    else begin
                        foreach (mem[i]) mem[i] = 16'hffff;
                        busy = BUSY_POLLS;
                        sr[7] = 1'b0;
                        sr[5] = sr[5] | erase_fail;
                    end
                end else sr = sr | 8'h30;
                mode = 2'd1;
                setup = 8'h00;
            end else if (setup == 8'h60) begin
                lock_code = dq_o[7:0];
                lock_blk = addr;
                setup = 8'h00;
            end else if (setup != 8'h00) begin
                last_prog = setup;
                mem[addr[3:0]] = mem[addr[3:0]] & dq_o;
                busy = BUSY_POLLS;
                sr[7] = 1'b0;
                mode = 2'd1;
                setup = 8'h00;
            end else begin
                setup = (dq_o[7:0] inside {8'h20, 8'h40, 8'h10, 8'hc0, 8'h60}) ? dq_o[7:0] : 8'h00;
                case (dq_o[7:0])
                    8'hff: mode = 2'd0;
                    8'h70: mode = 2'd1;
                    8'h90: mode = 2'd2;
                    8'h98: mode = 2'd3;
                    8'h50: sr = sr & 8'hc5;
                    default: ;
                endcase
            end
        end
    end
    always @(negedge oe_n) begin
        #1;
        if (!ce_n && mode == 2'd1 && busy > 0) begin
            busy = busy - 1;
            if (busy == 0) sr[7] = 1'b1;
        end
    end
    always @* case (mode)
        2'd0: rd = mem[addr[3:0]];
        2'd1: rd = {8'h00, sr};
        2'd2: rd = (addr == 22'h0) ? MAKER_CODE : {6'h00, addr[9:0]};
        default: rd = {8'h51, addr[7:0]};
    endcase
    always @* if (!ce_n && !oe_n) last_val = rd;
    // released bus shows the inverse of the last word
    assign dq_i = (!ce_n && !oe_n && rp_n) ? rd : ~last_val;
endmodule // fsc_flash_model

// [dv/fsc_host_monitor.sv]
// fsc_host_monitor: assertions on the pins and handshake of fsc_host
// assumes a bind to fsc_host; sees only its ports
`timescale 1ns/1ps
module fsc_host_monitor #(
    parameter int AW = 22,
    parameter int DW = 16
) (
    // clock and reset
    input wire logic          CLK_SYS,
    input wire logic          RESET,
    // user side
    input wire logic          REQ_VALID,
    input wire logic [3:0]    REQ_OP,
    input wire logic          REQ_READY,
    input wire logic          RSP_VALID,
    input wire logic          RSP_REFUSED,
    input wire logic          PROG_SUSPENDED,
    input wire logic          ERASE_SUSPENDED,
    // flash pins
    input wire logic          CE_N,
    input wire logic          OE_N,
    input wire logic          WE_N,
    input wire logic          POWER_DOWN_RESET_N,
    input wire logic [AW-1:0] ADDR,
    input wire logic [DW-1:0] DQ_O,
    input wire logic          DQ_OE_N
);
    wire idle_take = REQ_VALID && REQ_READY && !PROG_SUSPENDED && !ERASE_SUSPENDED;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    // ------------------------------------------------------------
    // pin sequences
    // ------------------------------------------------------------
    sequence s_write_low;
        (!WE_N && !CE_N && !DQ_OE_N) [*5];
    endsequence
    sequence s_read_low;
        (!OE_N && !CE_N && DQ_OE_N && WE_N) [*8];
    endsequence
    sequence s_erase_pair;
        ##[1:6] ($fell(WE_N) && DQ_O == 16'h0020) ##[8:16] ($fell(WE_N) && DQ_O == 16'h00d0);
    endsequence
    chk_reset_pins: assert property (disable iff (1'b0)
        RESET |=> !POWER_DOWN_RESET_N && CE_N && OE_N && WE_N && DQ_OE_N)
        else $error("pins not quiet during reset");
    chk_pdr_release: assert property ($fell(RESET) |=> POWER_DOWN_RESET_N)
        else $error("power down reset not released");
    chk_pdr_held: assert property (!$past(RESET) |-> POWER_DOWN_RESET_N)
        else $error("power down reset low while suspended");
    chk_write_pulse: assert property ($fell(WE_N) |-> s_write_low ##1 WE_N)
        else $error("write strobe length wrong");
    chk_write_stable: assert property (!WE_N && $past(WE_N) == 1'b0 |-> $stable(ADDR) && $stable(DQ_O))
        else $error("address or data moved during write");
    chk_read_pulse: assert property ($fell(OE_N) |-> s_read_low ##1 OE_N)
        else $error("read strobe length wrong");
    chk_erase_pair: assert property (idle_take && REQ_OP == fsc_pkg::OP_ERASE |-> s_erase_pair)
        else $error("erase command pair wrong");
    chk_refuse_quiet: assert property (idle_take && (REQ_OP == fsc_pkg::OP_RESUME ||
        REQ_OP == fsc_pkg::OP_SUSPEND) |=> CE_N throughout (##[0:2] (RSP_VALID && RSP_REFUSED)))
        else $error("idle suspend or resume not refused quietly");
    chk_rsp_pulse: assert property (RSP_VALID |=> !RSP_VALID)
        else $error("answer pulse longer than one cycle");
endmodule // fsc_host_monitor

// [dv/fsc_host_bench.sv]
// fsc_host_bench: directed scenarios for fsc_host against the flash model
// assumes fsc_pkg, fsc_host, fsc_flash_model and fsc_host_monitor compiled first
`timescale 1ns/1ps
module fsc_host_bench;
    localparam logic [15:0] MAKER = 16'h00a5;  // arbitrary value
    logic        clk_sys = 1'b0, reset = 1'b1, req_valid = 1'b0;
    logic [3:0]  req_op = 4'h0;
    logic [21:0] req_addr = 22'h0;
    logic [15:0] req_data = 16'h0, got_d;
    logic        erase_fail = 1'b0, supply_bad = 1'b0, got_r;
    logic [7:0]  got_s;
    wire         req_ready, rsp_valid, rsp_refused, p_susp, e_susp;
    wire         ce_n, oe_n, we_n, rp_n, dq_oe_n;
    wire  [15:0] rsp_data, dq_o, dq_i;
    wire  [7:0]  rsp_status;
    wire  [21:0] addr;
    int          error_cnt = 0, cmp_count = 0;
    always #5 clk_sys = ~clk_sys;
    fsc_host uut (.CLK_SYS(clk_sys), .RESET(reset), .REQ_VALID(req_valid), .REQ_OP(req_op),
        .REQ_ADDR(req_addr), .REQ_DATA(req_data), .REQ_READY(req_ready), .RSP_VALID(rsp_valid),
        .RSP_DATA(rsp_data), .RSP_STATUS(rsp_status), .RSP_REFUSED(rsp_refused),
        .PROG_SUSPENDED(p_susp), .ERASE_SUSPENDED(e_susp), .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n),
        .POWER_DOWN_RESET_N(rp_n), .ADDR(addr), .DQ_O(dq_o), .DQ_OE_N(dq_oe_n), .DQ_I(dq_i));
    fsc_flash_model #(.MAKER_CODE(MAKER)) flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .rp_n(rp_n), .addr(addr), .dq_o(dq_o), .dq_i(dq_i), .erase_fail(erase_fail),
        .supply_bad(supply_bad));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic do_op(input logic [3:0] op, input logic [21:0] a, input logic [15:0] d);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_op = op;
        req_addr = a;
        req_data = d;
        @(posedge clk_sys);
        while (req_ready !== 1'b1) @(posedge clk_sys);
        #1;
        req_valid = 1'b0;
        @(posedge clk_sys);
        while (rsp_valid !== 1'b1 && n < 5000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 5000) begin
            error_cnt++;
            test_done();
        end
        got_d = rsp_data;
        got_s = rsp_status;
        got_r = rsp_refused;
        #1;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reads();
        do_op(fsc_pkg::OP_READ_STAT, 22'h3a5a5, 16'h0);
        check(got_d, 16'h0080);
        do_op(fsc_pkg::OP_READ_CFG, 22'h0, 16'h0);
        check(got_d, MAKER);
        do_op(fsc_pkg::OP_READ_QRY, 22'h13, 16'h0);
        check(got_d, 16'h5113);
    endtask
    task automatic t_program();
        do_op(fsc_pkg::OP_PROGRAM, 22'h3, 16'h0ff0);
        check({8'h00, got_s}, 16'h0080);
        check({15'h0, (flash.last_prog inside {8'h40, 8'h10})}, 16'h1);
        do_op(fsc_pkg::OP_READ_ARRAY, 22'h0, 16'h0);
        do_op(fsc_pkg::OP_READ, 22'h3, 16'h0);
        check(got_d, 16'h0ff0);
        do_op(fsc_pkg::OP_PROT_PROG, 22'h2, 16'h1234);
        check({8'h00, flash.last_prog}, 16'h00c0);
    endtask
    task automatic t_erase();
        do_op(fsc_pkg::OP_PROGRAM, 22'h5, 16'h0000);
        do_op(fsc_pkg::OP_ERASE, 22'h20005, 16'h0);
        check({8'h00, got_s}, 16'h0080);
        check({10'h0, flash.erase_blk[21:16]}, 16'h0002);
        do_op(fsc_pkg::OP_CLEAR, 22'h0, 16'h0);
        do_op(fsc_pkg::OP_READ_ARRAY, 22'h0, 16'h0);
        do_op(fsc_pkg::OP_READ, 22'h5, 16'h0);
        check(got_d, 16'hffff);
    endtask
    task automatic t_faults();
        for (int i = 0; i < 2; i++) begin
            erase_fail = (i == 0);
            supply_bad = (i == 1);
            do_op(fsc_pkg::OP_ERASE, 22'h10000, 16'h0);
            check({8'h00, got_s}, (i == 0) ? 16'h00a0 : 16'h00a8);
            erase_fail = 1'b0;
            supply_bad = 1'b0;
            do_op(fsc_pkg::OP_CLEAR, 22'h0, 16'h0);
            do_op(fsc_pkg::OP_READ_STAT, 22'h0, 16'h0);
            check(got_d, 16'h0080);
        end
    endtask
    task automatic t_lock_refuse();
        logic [3:0] ops [3] = '{fsc_pkg::OP_LOCK, fsc_pkg::OP_UNLOCK, fsc_pkg::OP_LOCK_DOWN};
        logic [7:0] codes [3] = '{8'h01, 8'hd0, 8'h2f};
        for (int i = 0; i < 3; i++) begin
            do_op(ops[i], 22'h30000 + 22'(i), 16'h0);
            check({8'h00, flash.lock_code}, {8'h00, codes[i]});
            check(16'(flash.lock_blk[1:0]), 16'(i));
        end
        do_op(fsc_pkg::OP_RESUME, 22'h0, 16'h0);
        check({15'h0, got_r}, 16'h1);
        do_op(fsc_pkg::OP_SUSPEND, 22'h0, 16'h0);
        check({15'h0, got_r}, 16'h1);
        check({14'h0, p_susp, e_susp}, 16'h0);
    endtask
    task automatic test_done();
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        t_reads();
        t_program();
        t_erase();
        t_faults();
        t_lock_refuse();
        test_done();
    end
    initial begin
        #400000;
        error_cnt++;
        test_done();
    end
endmodule // fsc_host_bench
bind fsc_host fsc_host_monitor #(.AW(AW), .DW(DW)) u_mon (.CLK_SYS(CLK_SYS), .RESET(RESET),
    .REQ_VALID(REQ_VALID), .REQ_OP(REQ_OP), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
    .RSP_REFUSED(RSP_REFUSED), .PROG_SUSPENDED(PROG_SUSPENDED), .ERASE_SUSPENDED(ERASE_SUSPENDED),
    .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N), .POWER_DOWN_RESET_N(POWER_DOWN_RESET_N), .ADDR(ADDR),
    .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N));
